//--- hdl/sam_pkg.sv
// package of register map, field layout and reset values for the security alarm monitor
package sam_pkg;
  localparam int unsigned NUM_DET = 7;
  // detector bit positions
  localparam int unsigned DET_FREQ    = 0;
  localparam int unsigned DET_VOLT    = 1;
  localparam int unsigned DET_TEMP    = 2;
  localparam int unsigned DET_LIGHT   = 3;
  localparam int unsigned DET_INSUL   = 4;
  localparam int unsigned DET_SHIELD  = 5;
  localparam int unsigned DET_GLITCH  = 6;
  // access-fault bit positions in the fault status word
  localparam int unsigned FLT_ADDR    = 0;
  localparam int unsigned FLT_EXEC    = 1;
  localparam int unsigned FLT_PRIV    = 2;
  localparam int unsigned NUM_FLT     = 3;
  // register byte offsets
  localparam logic [11:0] OFS_DET_STATUS = 12'h000;
  localparam logic [11:0] OFS_DET_CLEAR  = 12'h004;
  localparam logic [11:0] OFS_REACT_CFG  = 12'h008;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h00c;
  localparam logic [11:0] OFS_IRQ_CLEAR  = 12'h010;
  localparam logic [11:0] OFS_IRQ_ENABLE = 12'h014;
  localparam logic [11:0] OFS_EXEC_ATTR  = 12'h018;
  localparam logic [11:0] OFS_RST_CAUSE  = 12'h01c;
  // reset values
  localparam logic [6:0]  RST_REACT_CFG  = 7'h7f;
  localparam logic [2:0]  RST_IRQ_ENABLE = 3'h0;
  localparam logic [1:0]  RST_EXEC_ATTR  = 2'h0;
  // cycles the chip reset request is held after the last triggering cycle
  localparam int unsigned RST_PULSE_CYC  = 4;
endpackage

//--- hdl/sam_monitor.sv
// security alarm monitor: detector capture, reaction select, access-fault fast interrupt
// Notes on behaviour
// - every detector event is caught in a bit software can read
// - software picks per detector: immediate reset or flag only
// - with reset selected, an event pulls chip reset at once
// - with flag selected, an event sets a status bit, no reset
// - seven inputs: frequency, voltage, temperature, light, insulation, shield, glitch
// - tampering stops operation by chip reset or fast interrupt request
// - access to a prohibited address raises a fast interrupt request
// - EEPROM execution checked against attributes; violation raises fast interrupt
// - security registers written only when the access attributes allow it
// - all registers return to defaults on power-on reset
// - detection is hardware only; software cannot mask or bypass it
//
// Register access over APB and the register offsets were chosen for this implementation.
module sam_monitor #(
  parameter int unsigned NDET = sam_pkg::NUM_DET
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            clk_en,
  // apb slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  input  wire logic [3:0]      pstrb,
  input  wire logic            pprot_priv,
  output logic                 pready,
  output logic [31:0]          prdata,
  output logic                 pslverr,
  // analog detector levels, asynchronous
  input  wire logic [NDET-1:0] det_in,
  // bus watch from the cpu side, same clock
  input  wire logic            bus_valid,
  input  wire logic            bus_addr_bad,
  input  wire logic            bus_fetch,
  input  wire logic            bus_eeprom,
  input  wire logic            bus_priv,
  // reactions
  output logic                 chip_rst_req,
  output logic                 fast_interrupt_request,
  output logic                 irq
);
  localparam int unsigned NF = sam_pkg::NUM_FLT;

  typedef struct packed {
    logic [NDET-1:0] sync1;
    logic [NDET-1:0] sync2;
    logic [NDET-1:0] det_status;
    logic [NDET-1:0] react_rst;
    logic [NF-1:0]   flt_status;
    logic [NF-1:0]   irq_en;
    logic [1:0]      exec_attr;
    logic [NDET-1:0] rst_cause;
    logic [2:0]      rst_cnt;
    logic [31:0]     rdata;
    logic            slverr;
  } sam_state_t;

  sam_state_t s_q;
  sam_state_t s_d;

  function automatic logic [31:0] sam_rd_mux(input sam_state_t s, input logic [11:0] a);
    logic [31:0] r;
    r = 32'h0;
    unique case (a)
      sam_pkg::OFS_DET_STATUS: r[NDET-1:0] = s.det_status;
      sam_pkg::OFS_REACT_CFG:  r[NDET-1:0] = s.react_rst;
      sam_pkg::OFS_IRQ_STATUS: r[NF-1:0]   = s.flt_status;
      sam_pkg::OFS_IRQ_ENABLE: r[NF-1:0]   = s.irq_en;
      sam_pkg::OFS_EXEC_ATTR:  r[1:0]      = s.exec_attr;
      sam_pkg::OFS_RST_CAUSE:  r[NDET-1:0] = s.rst_cause;
      default:                 r           = 32'h0;
    endcase
    return r;
  endfunction

  function automatic logic sam_mapped(input logic [11:0] a);
    return (a == sam_pkg::OFS_DET_STATUS) || (a == sam_pkg::OFS_DET_CLEAR) ||
           (a == sam_pkg::OFS_REACT_CFG)  || (a == sam_pkg::OFS_IRQ_STATUS) ||
           (a == sam_pkg::OFS_IRQ_CLEAR)  || (a == sam_pkg::OFS_IRQ_ENABLE) ||
           (a == sam_pkg::OFS_EXEC_ATTR)  || (a == sam_pkg::OFS_RST_CAUSE);
  endfunction

  logic            acc;
  logic            wr;
  logic            secure_reg;
  logic            deny;
  logic [NDET-1:0] det_evt;
  logic [NDET-1:0] trig_rst;
  logic            exec_bad;
  logic [NF-1:0]   flt_evt;
  logic [NDET-1:0] det_clr;
  logic [NF-1:0]   flt_clr;

  always_comb begin
    s_d        = s_q;
    acc        = psel && penable;
    // config, enable and attribute words are security registers
    secure_reg = (paddr == sam_pkg::OFS_REACT_CFG) || (paddr == sam_pkg::OFS_IRQ_ENABLE) ||
                 (paddr == sam_pkg::OFS_EXEC_ATTR);
    deny       = pwrite && secure_reg && !pprot_priv;
    wr         = acc && pwrite && pstrb[0] && sam_mapped(paddr) && !deny;
    // sampled after two flops; the first flop feeds only the second
    s_d.sync1  = det_in;
    s_d.sync2  = s_q.sync1;
    // no software term here: detection always runs
    det_evt    = s_q.sync2;
    trig_rst   = det_evt & s_q.react_rst;
    // exec attr bit0: eeprom execution forbidden, bit1: only privileged
    exec_bad   = bus_valid && bus_fetch && bus_eeprom &&
                 (s_q.exec_attr[0] || (s_q.exec_attr[1] && !bus_priv));
    flt_evt    = '0;
    flt_evt[sam_pkg::FLT_ADDR] = bus_valid && bus_addr_bad;
    flt_evt[sam_pkg::FLT_EXEC] = exec_bad;
    flt_evt[sam_pkg::FLT_PRIV] = acc && deny;
    det_clr    = '0;
    flt_clr    = '0;
    if (wr && paddr == sam_pkg::OFS_DET_CLEAR) begin
      det_clr = pwdata[NDET-1:0];
    end
    if (wr && paddr == sam_pkg::OFS_IRQ_CLEAR) begin
      flt_clr = pwdata[NF-1:0];
    end
    // set wins over clear so no event slips through
    s_d.det_status = (s_q.det_status & ~det_clr) | det_evt;
    s_d.flt_status = (s_q.flt_status & ~flt_clr) | flt_evt;
    if (|trig_rst) begin
      s_d.rst_cause = trig_rst;
      s_d.rst_cnt   = 3'(sam_pkg::RST_PULSE_CYC);
    end else if (s_q.rst_cnt != 3'h0) begin
      s_d.rst_cnt = s_q.rst_cnt - 3'h1;
    end
    if (wr && paddr == sam_pkg::OFS_REACT_CFG) begin
      s_d.react_rst = pwdata[NDET-1:0];
    end
    if (wr && paddr == sam_pkg::OFS_IRQ_ENABLE) begin
      s_d.irq_en = pwdata[NF-1:0];
    end
    if (wr && paddr == sam_pkg::OFS_EXEC_ATTR) begin
      s_d.exec_attr = pwdata[1:0];
    end
    s_d.rdata  = 32'h0;
    s_d.slverr = 1'b0;
    if (psel && !penable) begin
      s_d.rdata  = sam_rd_mux(s_q, paddr);
      s_d.slverr = !sam_mapped(paddr) || (pwrite && secure_reg && !pprot_priv);
    end
  end

  // reset reaction word narrowed to the detector count in use
  localparam logic [NDET-1:0] RST_REACT_LOCAL = NDET'(sam_pkg::RST_REACT_CFG);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q            <= '0;
      s_q.react_rst  <= RST_REACT_LOCAL;
      s_q.irq_en     <= sam_pkg::RST_IRQ_ENABLE;
      s_q.exec_attr  <= sam_pkg::RST_EXEC_ATTR;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // access phase always completes in one cycle after setup
  assign pready  = 1'b1;
  assign prdata  = s_q.rdata;
  assign pslverr = acc && s_q.slverr;
  // reset reaction acts in the same cycle the synchronised event appears
  assign chip_rst_req = (|(s_q.sync2 & s_q.react_rst)) || (s_q.rst_cnt != 3'h0);
  // fast interrupt ignores irq_en: access faults can never be masked
  assign fast_interrupt_request = |s_q.flt_status;
  assign irq = |(s_q.flt_status & s_q.irq_en);
endmodule

//--- testbench/sam_sensor_model.sv
// behavioural detector front end turning bench trip requests into sensor levels
module sam_sensor_model (
  input  wire logic       clk,
  input  wire logic [6:0] trip,
  output logic      [6:0] det_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // analog settling modelled as one cycle of lag
  always @(posedge clk) det_in <= trip;
endmodule

//--- testbench/sam_monitor_sva.sv
// port-level assertions for the security alarm monitor
module sam_monitor_sva #(
  parameter int unsigned NDET = 7
) (
  input wire logic            clk,
  input wire logic            rst_n,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [11:0]     paddr,
  input wire logic            pprot_priv,
  input wire logic            pslverr,
  input wire logic [NDET-1:0] det_in,
  input wire logic            bus_valid,
  input wire logic            bus_addr_bad,
  input wire logic            chip_rst_req,
  input wire logic            fast_interrupt_request,
  input wire logic            irq
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire acc = psel && penable;
  sequence refused_s; pslverr ##1 fast_interrupt_request; endsequence
  rst_cause_a: assert property (
    $rose(chip_rst_req) |-> $past(|det_in) || $past(|det_in, 2))
    else $error("reset request without detector event");
  rst_hold_a: assert property (
    $fell(chip_rst_req) |-> $past(det_in) == 0 && $past(det_in, 4) == 0)
    else $error("reset request dropped too early");
  unmapped_err_a: assert property (acc && paddr > 12'h01c |-> pslverr)
    else $error("unmapped access without error");
  status_read_a: assert property (acc && !pwrite && paddr == 12'h000 |-> !pslverr)
    else $error("status read flagged as error");
  user_write_a: assert property (acc && pwrite && !pprot_priv && paddr == 12'h008 |-> refused_s)
    else $error("user write to secure register not refused");
  addr_fault_a: assert property (bus_valid && bus_addr_bad |=> fast_interrupt_request)
    else $error("prohibited address gave no fast interrupt");
  fault_sticky_a: assert property (
    fast_interrupt_request && !(acc && pwrite && paddr == 12'h010) |=> fast_interrupt_request)
    else $error("fault flag lost without clear");
  irq_gate_a: assert property (irq |-> fast_interrupt_request)
    else $error("interrupt without fault status");
endmodule
bind sam_monitor sam_monitor_sva #(.NDET(NDET)) u_sva (.*);

//--- testbench/sam_monitor_tb.sv
// self-checking bench for the security alarm monitor
module sam_monitor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, psel, penable, pwrite, pprot_priv, pready, pslverr, er;
  logic bus_valid, bus_addr_bad, bus_fetch, bus_eeprom, bus_priv;
  logic chip_rst_req, fast_interrupt_request, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0]  trip, det_in;
  int          bad_count = 0;
  int          n_checks = 0;
  // enable and strobes held on: freeze and lane masking left unexercised
  sam_monitor DUT (.*, .clk_en(1'b1), .pstrb(4'hf));
  sam_sensor_model SENS (.*);
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic pv);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata, pprot_priv} <= {2'b10, w, a, d, pv};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0, 1'b1);
    chk(nm, rd, exp);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #300000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    {rst_n, psel, penable, pwrite, pprot_priv, paddr, pwdata, trip} = '0;
    {bus_valid, bus_addr_bad, bus_fetch, bus_eeprom, bus_priv} = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rc("det_status", 12'h000, 0);
    chk("pready", pready, 1);
    rc("react_cfg", 12'h008, 32'h7f);
    rc("irq_enable", 12'h014, 0);
    rc("exec_attr", 12'h018, 0);
    rc("unmapped", 12'h020, 0);
    chk("unmapped_err", er, 1);
    apb(1'b1, 12'h008, 0, 1'b0);
    chk("user_wr_err", er, 1);
    rc("react_kept", 12'h008, 32'h7f);
    rc("fault_priv", 12'h00c, 4);
    trip <= 7'h01;
    repeat (5) @(posedge clk);
    chk("rst_react", chip_rst_req, 1);
    trip <= 7'h00;
    repeat (12) @(posedge clk);
    chk("rst_done", chip_rst_req, 0);
    rc("det_sticky", 12'h000, 1);
    rc("rst_cause", 12'h01c, 1);
    apb(1'b1, 12'h004, 1, 1'b1);
    rc("det_clear", 12'h000, 0);
    apb(1'b1, 12'h008, 0, 1'b1);
    for (int i = 0; i < 7; i++) begin
      trip <= 7'(1 << i);
      repeat (5) @(posedge clk);
      chk("flag_no_rst", chip_rst_req, 0);
      trip <= 7'h00;
      rc("det_flag", 12'h000, 1 << i);
      apb(1'b1, 12'h004, 32'h7f, 1'b1);
    end
    apb(1'b1, 12'h010, 7, 1'b1);
    {bus_valid, bus_addr_bad} <= 2'b11;
    @(posedge clk);
    {bus_valid, bus_addr_bad} <= 2'b00;
    @(posedge clk);
    chk("addr_fast", fast_interrupt_request, 1);
    chk("irq_masked", irq, 0);
    apb(1'b1, 12'h014, 1, 1'b1);
    @(posedge clk);
    chk("irq_on", irq, 1);
    apb(1'b1, 12'h018, 1, 1'b1);
    {bus_valid, bus_fetch, bus_eeprom} <= 3'b111;
    @(posedge clk);
    {bus_valid, bus_fetch, bus_eeprom} <= 3'b000;
    rc("exec_fault", 12'h00c, 3);
    apb(1'b1, 12'h010, 3, 1'b1);
    // privileged-only attribute: privileged fetch passes, user fetch faults
    apb(1'b1, 12'h018, 2, 1'b1);
    {bus_valid, bus_fetch, bus_eeprom, bus_priv} <= 4'b1111;
    @(posedge clk);
    {bus_valid, bus_fetch, bus_eeprom, bus_priv} <= 4'b0000;
    rc("exec_priv_ok", 12'h00c, 0);
    {bus_valid, bus_fetch, bus_eeprom} <= 3'b111;
    @(posedge clk);
    {bus_valid, bus_fetch, bus_eeprom} <= 3'b000;
    rc("exec_user_bad", 12'h00c, 2);
    apb(1'b1, 12'h010, 2, 1'b1);
    @(posedge clk);
    chk("fast_clear", fast_interrupt_request, 0);
    chk("irq_off", irq, 0);
    tally_and_finish();
  end
endmodule
